// *** verilog/serial_port_params.svh ***
// constants of the dual mode serial port
`ifndef SERIAL_PORT_PARAMS_SVH
`define SERIAL_PORT_PARAMS_SVH
// ---------------------------------------------
// register offsets
// ---------------------------------------------
`define OFS_ASYNC_CFG   16'hFF70
`define OFS_RX_ERR      16'hFF71
`define OFS_SYNC_CTL    16'hFF72
`define OFS_PRESCALE    16'hFF73
`define OFS_SHIFT_DATA  16'hFF74
`define OFS_SYNC_STAT   16'hFF75
// ---------------------------------------------
// field positions, masks, limits and reset values
// ---------------------------------------------
`define BIT_TX_EN       7
`define BIT_RX_EN       6
`define BIT_PAR_HI      5
`define BIT_PAR_LO      4
`define BIT_CHAR_LEN    3
`define BIT_STOP_LEN    2
`define BIT_SYNC_EN     7
`define BIT_FIRST_BIT   2
`define BIT_CLK_SRC     1
`define SYNC_CTL_MASK   8'h86
`define ASYNC_CFG_MASK  8'hFC
`define PRESCALE_MASK   8'hF0
`define REG_RESET       8'h00
`define PRESCALE_MAX    4'h7
`define BITS_PER_XFER   4'h8
`endif

// *** verilog/serial_port_pkg.sv ***
// types of the dual mode serial port
package serial_port_pkg;
  typedef enum logic [1:0] {
    PAR_NONE,
    PAR_ZERO,
    PAR_ODD,
    PAR_EVEN
  } parity_mode_t;
  typedef enum logic [1:0] {
    SX_IDLE,
    SX_LOW,
    SX_HIGH
  } sync_state_t;
endpackage

// *** verilog/prescale_div.sv ***
// prescaler: one cycle enable at fx/2^(n+1)
`timescale 1ns/1ps
module prescale_div
  import serial_port_pkg::*;
#(
  parameter int W = 9
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // control
  input  wire logic       i_run,
  input  wire logic [3:0] i_sel,
  // enable
  output logic            o_tick
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } div_t;
  div_t st_r;
  div_t st_nxt;
  logic [W-1:0] last;
  always_comb begin
    // half period of serial clock is 2^(n+1) cycles
    last = W'((1 << (4'(i_sel[2:0]) + 4'd1)) - 1);
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (!i_run) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt >= last) begin
      st_nxt.cnt = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + W'(1);
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign o_tick = st_r.tick;
endmodule

// *** verilog/dual_mode_serial_port.sv ***
// serial unit: register port, 3-wire engine, async config and rx status
`timescale 1ns/1ps
`include "serial_port_params.svh"
module dual_mode_serial_port
  import serial_port_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // register port
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [7:0]       o_rdata,
  // async receiver results
  input  wire logic        i_rx_frame_done,
  input  wire logic [7:0]  i_rx_frame_data,
  input  wire logic        i_rx_parity_bit,
  input  wire logic        i_rx_framing_err,
  input  wire logic        i_rx_frame_past_stop,
  // async config outputs
  output logic             o_tx_enable,
  output logic             o_rx_enable,
  output logic [1:0]       o_parity_mode,
  output logic             o_char_8bit,
  output logic             o_two_stop,
  output logic [7:0]       o_tx_data,
  output logic             o_tx_load,
  // events
  output logic             o_rx_done_irq,
  output logic             o_sync_done_irq,
  // serial pins
  input  wire logic        i_sck,
  output logic             o_sck,
  output logic             o_sck_oe,
  output logic             o_so,
  input  wire logic        i_si
);
  // ---------------------------------------------
  // state
  // ---------------------------------------------
  typedef struct packed {
    logic [7:0]  async_cfg;
    logic [7:0]  sync_ctl;
    logic [7:0]  prescale;
    logic [7:0]  shift;
    logic [7:0]  rx_buf;
    logic [2:0]  rx_err;
    logic        overrun_armed;
    logic [7:0]  rdata;
    sync_state_t sx;
    logic [3:0]  bitcnt;
    logic        so;
    logic        sck;
    logic        sck_oe;
    logic        sin_s0;
    logic        sin_s1;
    logic        sin_prev;
    logic        sample;
    logic        sync_irq;
    logic        rx_irq;
    logic        tx_load;
  } port_t;
  port_t st_r;
  port_t st_nxt;
  logic  tick;
  logic  run_int;
  logic  int_clk;
  logic  msb_first;
  logic  ext_fall;
  logic  ext_rise;
  logic  fall_ev;
  logic  rise_ev;
  logic  data_wr;
  logic  rx_read;
  logic  par_err;
  logic [7:0] rx_in;
  // ---------------------------------------------
  // prescaler
  // ---------------------------------------------
  assign int_clk = st_r.sync_ctl[`BIT_CLK_SRC];
  assign run_int = int_clk && st_r.sx != SX_IDLE;
  prescale_div #(.W(9)) u_div (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_run   (run_int),
    .i_sel   (st_r.prescale[7:4]),
    .o_tick  (tick)
  );
  // ---------------------------------------------
  // decode
  // ---------------------------------------------
  assign msb_first = !st_r.sync_ctl[`BIT_FIRST_BIT];
  assign data_wr   = i_wr && i_addr == `OFS_SHIFT_DATA;
  assign rx_read   = i_rd && i_addr == `OFS_SHIFT_DATA;
  assign ext_fall  = st_r.sin_prev && !st_r.sin_s1;
  assign ext_rise  = !st_r.sin_prev && st_r.sin_s1;
  assign fall_ev   = int_clk ? (tick && st_r.sx == SX_HIGH) : ext_fall;
  assign rise_ev   = int_clk ? (tick && st_r.sx == SX_LOW) : ext_rise;
  always_comb begin
    rx_in = i_rx_frame_data;
    if (!st_r.async_cfg[`BIT_CHAR_LEN]) begin
      rx_in[7] = 1'b0;
    end
  end
  always_comb begin
    logic odd_cnt;
    odd_cnt = ^{i_rx_frame_data[6:0], i_rx_parity_bit}
              ^ (st_r.async_cfg[`BIT_CHAR_LEN] & i_rx_frame_data[7]);
    unique case (parity_mode_t'(st_r.async_cfg[5:4]))
      PAR_ODD:  par_err = !odd_cnt;
      PAR_EVEN: par_err = odd_cnt;
      PAR_NONE,
      PAR_ZERO: par_err = 1'b0;
    endcase
  end
  // ---------------------------------------------
  // next state
  // ---------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync_irq = 1'b0;
    st_nxt.rx_irq = 1'b0;
    st_nxt.tx_load = 1'b0;
    // external clock pin through two flops
    st_nxt.sin_s0 = i_sck;
    st_nxt.sin_s1 = st_r.sin_s0;
    st_nxt.sin_prev = st_r.sin_s1;
    // register writes
    if (i_wr) begin
      unique case (i_addr)
        `OFS_ASYNC_CFG: st_nxt.async_cfg = i_wdata & `ASYNC_CFG_MASK;
        `OFS_SYNC_CTL:  st_nxt.sync_ctl = i_wdata & `SYNC_CTL_MASK;
        `OFS_PRESCALE: begin
          st_nxt.prescale = i_wdata & `PRESCALE_MASK;
          if (i_wdata[7:4] > `PRESCALE_MAX) begin
            st_nxt.prescale[7:4] = `PRESCALE_MAX;
          end
        end
        default: ;
      endcase
    end
    // data write: load shift, start only if enabled and idle
    if (data_wr) begin
      st_nxt.shift = i_wdata;
      st_nxt.tx_load = 1'b1;
      if (st_r.sync_ctl[`BIT_SYNC_EN] && st_r.sx == SX_IDLE &&
          (int_clk || st_r.sin_s1)) begin
        st_nxt.sx = SX_HIGH;
        st_nxt.bitcnt = 4'h0;
        st_nxt.so = msb_first ? i_wdata[7] : i_wdata[0];
        st_nxt.sck_oe = int_clk;
      end
    end
    // 3-wire engine
    if (!st_r.sync_ctl[`BIT_SYNC_EN]) begin
      st_nxt.sx = SX_IDLE;
      st_nxt.sck = 1'b1;
      st_nxt.sck_oe = 1'b0;
    end else if (st_r.sx != SX_IDLE) begin
      if (fall_ev) begin
        st_nxt.sx = SX_LOW;
        st_nxt.sck = !int_clk;
        if (st_r.bitcnt != 4'h0) begin
          st_nxt.shift = msb_first ? {st_r.shift[6:0], st_r.sample}
                                   : {st_r.sample, st_r.shift[7:1]};
          st_nxt.so = msb_first ? st_r.shift[6] : st_r.shift[1];
        end
      end else if (rise_ev) begin
        st_nxt.sck = 1'b1;
        st_nxt.sample = i_si;
        st_nxt.bitcnt = st_r.bitcnt + 4'h1;
        if (st_r.bitcnt + 4'h1 == `BITS_PER_XFER) begin
          st_nxt.shift = msb_first ? {st_r.shift[6:0], i_si}
                                   : {i_si, st_r.shift[7:1]};
          st_nxt.sx = SX_IDLE;
          st_nxt.sync_irq = 1'b1;
          st_nxt.sck_oe = 1'b0;
        end else begin
          st_nxt.sx = SX_HIGH;
        end
      end
    end else begin
      st_nxt.sck = 1'b1;
    end
    // async rx status
    if (rx_read) begin
      st_nxt.rx_err = 3'h0;
      st_nxt.overrun_armed = 1'b0;
    end
    if (i_rx_frame_done) begin
      if (st_r.async_cfg[`BIT_RX_EN]) begin
        st_nxt.rx_buf = rx_in;
        st_nxt.rx_err = {par_err, i_rx_framing_err, st_r.overrun_armed};
        st_nxt.overrun_armed = 1'b1;
        st_nxt.rx_irq = 1'b1;
      end else if (i_rx_frame_past_stop) begin
        st_nxt.rx_buf = rx_in;
      end
    end
    // read data, one cycle after strobe
    st_nxt.rdata = 8'h00;
    if (i_rd) begin
      unique case (i_addr)
        `OFS_ASYNC_CFG:  st_nxt.rdata = st_r.async_cfg;
        `OFS_RX_ERR:     st_nxt.rdata = {5'h00, st_r.rx_err};
        `OFS_SYNC_CTL:   st_nxt.rdata = st_r.sync_ctl;
        `OFS_PRESCALE:   st_nxt.rdata = st_r.prescale;
        `OFS_SHIFT_DATA: st_nxt.rdata = st_r.sync_ctl[`BIT_SYNC_EN] ? st_r.shift
                                                                   : st_r.rx_buf;
        `OFS_SYNC_STAT:  st_nxt.rdata = {7'h00, st_r.sx != SX_IDLE};
        default:         st_nxt.rdata = 8'h00;
      endcase
    end
  end
  // ---------------------------------------------
  // registers
  // ---------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_r <= '0;
      st_r.sck <= 1'b1;
      st_r.so <= 1'b1;
      st_r.sin_s0 <= 1'b1;
      st_r.sin_s1 <= 1'b1;
      st_r.sin_prev <= 1'b1;
      st_r.sx <= SX_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end
  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign o_rdata         = st_r.rdata;
  assign o_tx_enable     = st_r.async_cfg[`BIT_TX_EN];
  assign o_rx_enable     = st_r.async_cfg[`BIT_RX_EN];
  assign o_parity_mode   = st_r.async_cfg[5:4];
  assign o_char_8bit     = st_r.async_cfg[`BIT_CHAR_LEN];
  assign o_two_stop      = st_r.async_cfg[`BIT_STOP_LEN];
  assign o_tx_data       = st_r.shift;
  assign o_tx_load       = st_r.tx_load;
  assign o_rx_done_irq   = st_r.rx_irq;
  assign o_sync_done_irq = st_r.sync_irq;
  assign o_sck           = st_r.sck;
  assign o_sck_oe        = st_r.sck_oe;
  assign o_so            = st_r.so;
endmodule

// *** testbench/serial_port_assertions.sv ***
// assertions on the ports of the serial unit
`timescale 1ns/1ps
`include "serial_port_params.svh"
module serial_port_checker (
  // clock, reset, register port
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic [15:0] i_addr,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [7:0]  o_rdata,
  // async side
  input wire logic        i_rx_frame_done,
  input wire logic        o_tx_enable,
  input wire logic        o_rx_enable,
  input wire logic [1:0]  o_parity_mode,
  input wire logic        o_char_8bit,
  input wire logic        o_two_stop,
  input wire logic        o_rx_done_irq,
  // 3-wire side
  input wire logic        o_sync_done_irq,
  input wire logic        o_sck,
  input wire logic        o_sck_oe,
  input wire logic        o_so
);
  // ---------------------------------------------
  // properties
  // ---------------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_sync_rsvd: assert property ($past(i_rd) && $past(i_addr) == `OFS_SYNC_CTL
    |-> (o_rdata & 8'h79) == 8'h00) else $error("sync control reserved bits set");
  a_prescale_low: assert property ($past(i_rd) && $past(i_addr) == `OFS_PRESCALE
    |-> o_rdata[3:0] == 4'h0) else $error("prescale low bits not zero");
  a_sck_idle: assert property (!o_sck_oe |-> o_sck)
    else $error("serial clock not idle high");
  a_so_on_fall: assert property (o_sck_oe && $past(o_sck_oe) && $changed(o_so)
    |-> $fell(o_sck)) else $error("data out moved off falling edge");
  a_start_cause: assert property ($rose(o_sck_oe)
    |-> $past(i_wr) && $past(i_addr) == `OFS_SHIFT_DATA) else $error("transfer without write");
  a_done_stop: assert property (o_sync_done_irq |-> ##[0:3] (!o_sck_oe && o_sck))
    else $error("engine did not stop after done");
  a_irq_cause: assert property (o_rx_done_irq
    |-> $past(i_rx_frame_done) && $past(o_rx_enable)) else $error("rx irq without frame");
  a_cfg_cause: assert property ($changed({o_tx_enable, o_rx_enable, o_parity_mode,
    o_char_8bit, o_two_stop}) |-> $past(i_wr) && $past(i_addr) == `OFS_ASYNC_CFG)
    else $error("async config changed without write");
  c_sync_done: cover property (o_sync_done_irq);
  c_rx_irq: cover property (o_rx_done_irq);
  c_start: cover property ($rose(o_sck_oe));
endmodule
bind dual_mode_serial_port serial_port_checker chk_i (.i_clk, .i_rst_n, .i_addr, .i_wr,
  .i_rd, .o_rdata, .i_rx_frame_done, .o_tx_enable, .o_rx_enable, .o_parity_mode,
  .o_char_8bit, .o_two_stop, .o_rx_done_irq, .o_sync_done_irq, .o_sck, .o_sck_oe, .o_so);

// *** testbench/sync_peer.sv ***
// far side peer: 3-wire shift register, msb first on the wire
`timescale 1ns/1ps
module sync_peer (
  // serial lines
  input  wire logic       i_sck,
  input  wire logic       i_so,
  output logic            o_si,
  // bench side
  input  wire logic       i_load,
  input  wire logic [7:0] i_tx,
  output logic [7:0]      o_rx
);
  logic [7:0] sh;
  logic       so_q;
  assign o_si = so_q;
  // each fall moves the next bit into the output latch, idle bits toggle
  always @(posedge i_load or negedge i_sck) begin
    if (i_load) begin
      sh <= i_tx;
    end else begin
      so_q <= sh[7];
      sh <= {sh[6:0], ~sh[7]};
    end
  end
  // capture on rise
  always @(posedge i_sck) o_rx <= {o_rx[6:0], i_so};
endmodule

// *** testbench/testbench.sv ***
// bench for the serial unit
`timescale 1ns/1ps
`include "serial_port_params.svh"
module testbench;
  logic i_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, i_sck = 1, load = 0, irq;
  logic i_rx_frame_done = 0, i_rx_parity_bit = 0, i_rx_frame_past_stop = 0;
  logic i_rx_framing_err = 0;
  logic [15:0] i_addr = 0;
  logic [7:0]  i_wdata = 0, i_rx_frame_data = 0, ptx = 0, cfg, d, last;
  logic [7:0]  o_rdata, o_tx_data, prx, mdl [int];
  logic [1:0]  o_parity_mode;
  logic o_tx_enable, o_rx_enable, o_char_8bit, o_two_stop, o_tx_load, o_rx_done_irq;
  logic o_sync_done_irq, o_sck, o_sck_oe, o_so, i_si;
  int error_cnt = 0, n_tests = 0, ones;
  wire logic sck_line = o_sck_oe ? o_sck : i_sck;
  always #12.5 i_clk = ~i_clk;
  dual_mode_serial_port DUT (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_rx_frame_done, .i_rx_frame_data, .i_rx_parity_bit, .i_rx_framing_err,
    .i_rx_frame_past_stop, .o_tx_enable, .o_rx_enable, .o_parity_mode, .o_char_8bit,
    .o_two_stop, .o_tx_data, .o_tx_load, .o_rx_done_irq, .o_sync_done_irq, .i_sck,
    .o_sck, .o_sck_oe, .o_so, .i_si);
  sync_peer peer (.i_sck(sck_line), .i_so(o_so), .o_si(i_si), .i_load(load), .i_tx(ptx),
    .o_rx(prx));
  // ---------------------------------------------
  // tasks
  // ---------------------------------------------
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    if (a == `OFS_ASYNC_CFG) mdl[a] = v & `ASYNC_CFG_MASK;
    if (a == `OFS_SYNC_CTL) mdl[a] = v & `SYNC_CTL_MASK;
    if (a == `OFS_PRESCALE) mdl[a] = (v[7:4] > 4'h7) ? 8'h70 : (v & `PRESCALE_MASK);
  endtask
  task rchk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask
  task frame(input logic [7:0] v, input logic pb, input logic ps);
    @(posedge i_clk);
    i_rx_frame_data <= v;
    i_rx_parity_bit <= pb;
    i_rx_frame_past_stop <= ps;
    i_rx_frame_done <= 1'b1;
    @(posedge i_clk);
    i_rx_frame_done <= 1'b0;
    #1 irq = o_rx_done_irq;
  endtask
  task xfer(input logic [3:0] c, input logic lsb, input logic ext);
    logic [7:0] dt, pt, ed, ep;
    int lo;
    dt = $urandom;
    pt = $urandom;
    lo = 0;
    ed = pt;
    ep = dt;
    if (lsb) begin
      ed = {<<{pt}};
      ep = {<<{dt}};
    end
    wr(`OFS_PRESCALE, {c, 4'h0});
    wr(`OFS_SYNC_CTL, {5'b10000, lsb, !ext, 1'b0});
    ptx = pt;
    load <= 1'b1;
    @(posedge i_clk);
    load <= 1'b0;
    wr(`OFS_SHIFT_DATA, dt);
    for (int t = 0; t < 5000 && o_sync_done_irq !== 1'b1; t++) begin
      @(posedge i_clk);
      if (ext) i_sck <= (t < 128) ? t[3] : 1'b1;
      #1 if (o_sck_oe === 1'b1 && o_sck === 1'b0) lo++;
    end
    chk(8'(o_sync_done_irq), 8'h01);
    chk(8'(lo), ext ? 8'h00 : 8'(8 << (c + 1)));
    chk(prx, ep);
    rchk(`OFS_SHIFT_DATA, ed);
  endtask
  task test_done;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ---------------------------------------------
  // sequence
  // ---------------------------------------------
  initial begin
    void'($urandom(30));
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    for (int k = 0; k < 4; k++) rchk(16'hFF70 + 16'(k), 8'h00);
    wr(`OFS_SYNC_CTL, 8'h86);
    rchk(`OFS_SYNC_CTL, mdl[`OFS_SYNC_CTL]);
    for (int c = 0; c < 16; c += 5) begin
      wr(`OFS_PRESCALE, {4'(c), 4'($urandom)});
      rchk(`OFS_PRESCALE, mdl[`OFS_PRESCALE]);
    end
    wr(16'hFF7F, 8'h5A);
    rchk(16'hFF7F, 8'h00);
    wr(`OFS_SYNC_CTL, 8'h00);
    for (int p = 0; p < 4; p++) begin
      cfg = {2'b11, 2'(p), p[0], 3'b100};
      wr(`OFS_ASYNC_CFG, cfg);
      rchk(`OFS_ASYNC_CFG, mdl[`OFS_ASYNC_CFG]);
      d = {2'b00, o_tx_enable, o_rx_enable, o_parity_mode, o_char_8bit, o_two_stop};
      chk(d, {2'b00, cfg[7:2]});
      d = $urandom;
      last = p[0] ? d : {1'b0, d[6:0]};
      ones = $countones(last) + 32'(p % 2 == 0 ? 1'b0 : 1'b1);
      frame(d, p % 2 != 0, 1'b0);
      chk(8'(irq), 8'h01);
      cfg = {5'b0, (p == 2 && ones % 2 == 0) || (p == 3 && ones % 2 == 1), 2'b0};
      rchk(`OFS_RX_ERR, cfg);
      rchk(`OFS_SHIFT_DATA, last);
      rchk(`OFS_RX_ERR, 8'h00);
    end
    wr(`OFS_ASYNC_CFG, 8'h08);
    frame(8'hA5, 1'b0, 1'b0);
    chk(8'(irq), 8'h00);
    rchk(`OFS_SHIFT_DATA, last);
    frame(8'h3C, 1'b0, 1'b1);
    chk(8'(irq), 8'h00);
    rchk(`OFS_SHIFT_DATA, 8'h3C);
    wr(`OFS_ASYNC_CFG, 8'h80);
    wr(`OFS_ASYNC_CFG, 8'h00);
    wr(`OFS_SHIFT_DATA, 8'hFF);
    #1 chk(8'(o_tx_load), 8'h01);
    chk(o_tx_data, 8'hFF);
    wr(`OFS_ASYNC_CFG, 8'h80);
    #1 chk(8'(o_tx_enable), 8'h01);
    wr(`OFS_ASYNC_CFG, 8'h00);
    wr(`OFS_SHIFT_DATA, 8'h5A);
    wr(`OFS_SYNC_CTL, 8'h82);
    repeat (20) @(posedge i_clk);
    #1 chk(8'(o_sck_oe), 8'h00);
    rchk(`OFS_SYNC_STAT, 8'h00);
    for (int k = 0; k < 6; k++) xfer(4'(k / 2), k % 2 != 0, k > 3);
    test_done();
  end
  initial begin
    repeat (30000) @(posedge i_clk);
    error_cnt++;
    test_done();
  end
endmodule
